// ---- hdl/pchm_fan_tach.sv ----
`timescale 1ns/1ps
module pchm_fan_tach (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         sec_tick,
   input  wire logic                         tach,
   input  wire logic [pchm_pkg::SPEED_W-1:0] min_speed,
   output logic      [pchm_pkg::SPEED_W-1:0] speed,
   output logic                              fail
);

   logic                         tach_prev;
   logic [pchm_pkg::SPEED_W-1:0] pulse_cnt;
   wire                          tach_rise;
   wire                          cnt_full;

   assign tach_rise = tach & ~tach_prev;
   assign cnt_full  = &pulse_cnt;

   // pulses per second, latched each second; a fan below minimum has failed
   always_ff @(posedge clk) begin
      if (rst) begin
         tach_prev <= 1'b0;
         pulse_cnt <= '0;
         speed     <= '0;
         fail      <= 1'b0;
      end else begin
         tach_prev <= tach;
         if (sec_tick) begin
            speed     <= pulse_cnt;
            fail      <= (pulse_cnt < min_speed);
            pulse_cnt <= {{(pchm_pkg::SPEED_W-1){1'b0}}, tach_rise};
         end else if (tach_rise && !cnt_full) begin
            pulse_cnt <= pulse_cnt + 16'h0001;
         end
      end
   end

endmodule : pchm_fan_tach

// ---- hdl/pchm_monitor.sv ----
`timescale 1ns/1ps
// Operation
// - sample cpu, supply and intake-air temperatures
// - over threshold: fans full, raise event
// - temp error clears: all below plus acknowledge
// - supply threshold held within 40..80 C
// - intake-air threshold held within 25..65 C
// - supervisor idle after cold_hardware_restart
// - missed retrigger: expired flag plus event
// - software enables supervisor and reset reaction
// - timeout 3..255 seconds in one-second steps
// - timeout write while running restarts countdown
// - watch cpu and supply fans, event
// - fan error clears: fan ok plus acknowledge
// - both fan speeds readable by software
module pchm_monitor #(
   parameter int TICKS_PER_SEC = pchm_pkg::SEC_CYCLES
) (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic [pchm_pkg::ADDR_W-1:0]  addr,
   input  wire logic [pchm_pkg::DATA_W-1:0]  wr_data,
   input  wire logic                         wr_en,
   input  wire logic                         rd_en,
   output logic      [pchm_pkg::DATA_W-1:0]  rd_data,
   input  wire logic [pchm_pkg::TEMP_W-1:0]  temp_cpu,
   input  wire logic [pchm_pkg::TEMP_W-1:0]  temp_psu,
   input  wire logic [pchm_pkg::TEMP_W-1:0]  temp_air,
   input  wire logic                         tach_cpu_fan,
   input  wire logic                         tach_psu_fan,
   output logic                              fan_full_speed,
   output logic                              system_reset,
   output logic                              irq
);

   // one-second timebase
   logic [pchm_pkg::TICK_W-1:0] tick_cnt;
   logic                        sec_tick;
   wire                         tick_wrap;

   assign tick_wrap = (tick_cnt == pchm_pkg::TICK_W'(TICKS_PER_SEC - 1));

   always_ff @(posedge clk) begin
      if (rst) begin
         tick_cnt <= '0;
         sec_tick <= 1'b0;
      end else begin
         tick_cnt <= tick_wrap ? '0 : tick_cnt + 24'h000001;
         sec_tick <= tick_wrap;
      end
   end

   // register decode
   wire wr_ctrl    = wr_en && (addr == pchm_pkg::ADDR_CTRL);
   wire wr_timeout = wr_en && (addr == pchm_pkg::ADDR_TIMEOUT);
   wire wr_retrig  = wr_en && (addr == pchm_pkg::ADDR_RETRIGGER);
   wire wr_thr_cpu = wr_en && (addr == pchm_pkg::ADDR_THR_CPU);
   wire wr_thr_psu = wr_en && (addr == pchm_pkg::ADDR_THR_PSU);
   wire wr_thr_air = wr_en && (addr == pchm_pkg::ADDR_THR_AIR);
   wire wr_error   = wr_en && (addr == pchm_pkg::ADDR_ERROR);
   wire wr_irq_clr = wr_en && (addr == pchm_pkg::ADDR_IRQ_CLEAR);
   wire wr_irq_en  = wr_en && (addr == pchm_pkg::ADDR_IRQ_ENABLE);
   wire wr_fan_min = wr_en && (addr == pchm_pkg::ADDR_FAN_MIN);

   wire [pchm_pkg::TEMP_W-1:0] wr_byte = wr_data[pchm_pkg::TEMP_W-1:0];

   // control and configuration
   logic [1:0]                   ctrl;
   logic [pchm_pkg::TOUT_W-1:0]  supervisor_timeout_seconds;
   logic [pchm_pkg::TEMP_W-1:0]  thr_cpu;
   logic [pchm_pkg::TEMP_W-1:0]  thr_psu;
   logic [pchm_pkg::TEMP_W-1:0]  thr_air;
   logic [pchm_pkg::SPEED_W-1:0] fan_min;
   logic [pchm_pkg::EVT_W-1:0]   irq_enable;

   // clamp writes into the allowed ranges
   wire [pchm_pkg::TEMP_W-1:0] next_thr_psu =
      (wr_byte < pchm_pkg::THR_PSU_MIN) ? pchm_pkg::THR_PSU_MIN :
      (wr_byte > pchm_pkg::THR_PSU_MAX) ? pchm_pkg::THR_PSU_MAX : wr_byte;
   wire [pchm_pkg::TEMP_W-1:0] next_thr_air =
      (wr_byte < pchm_pkg::THR_AIR_MIN) ? pchm_pkg::THR_AIR_MIN :
      (wr_byte > pchm_pkg::THR_AIR_MAX) ? pchm_pkg::THR_AIR_MAX : wr_byte;
   wire [pchm_pkg::TOUT_W-1:0] next_timeout =
      (wr_byte < pchm_pkg::TOUT_MIN) ? pchm_pkg::TOUT_MIN :
      (wr_byte > pchm_pkg::TOUT_MAX) ? pchm_pkg::TOUT_MAX : wr_byte;

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl                       <= pchm_pkg::CTRL_RST;
         supervisor_timeout_seconds <= pchm_pkg::TOUT_RST;
         thr_cpu                    <= pchm_pkg::THR_CPU_RST;
         thr_psu                    <= pchm_pkg::THR_PSU_RST;
         thr_air                    <= pchm_pkg::THR_AIR_RST;
         fan_min                    <= pchm_pkg::FAN_MIN_RST;
         irq_enable                 <= pchm_pkg::EVT_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl <= wr_data[1:0];
         end
         if (wr_timeout) begin
            supervisor_timeout_seconds <= next_timeout;
         end
         if (wr_thr_cpu) begin
            thr_cpu <= wr_byte;
         end
         if (wr_thr_psu) begin
            thr_psu <= next_thr_psu;
         end
         if (wr_thr_air) begin
            thr_air <= next_thr_air;
         end
         if (wr_fan_min) begin
            fan_min <= wr_data;
         end
         if (wr_irq_en) begin
            irq_enable <= wr_data[pchm_pkg::EVT_W-1:0];
         end
      end
   end

   wire program_supervisor_en = ctrl[pchm_pkg::CTRL_WD_EN_BIT];
   wire reset_react_en        = ctrl[pchm_pkg::CTRL_RST_EN_BIT];

   // temperature sampling and comparison
   logic [pchm_pkg::TEMP_W-1:0] cur_cpu;
   logic [pchm_pkg::TEMP_W-1:0] cur_psu;
   logic [pchm_pkg::TEMP_W-1:0] cur_air;

   always_ff @(posedge clk) begin
      if (rst) begin
         cur_cpu <= '0;
         cur_psu <= '0;
         cur_air <= '0;
      end else begin
         cur_cpu <= temp_cpu;
         cur_psu <= temp_psu;
         cur_air <= temp_air;
      end
   end

   wire any_over = (cur_cpu > thr_cpu) || (cur_psu > thr_psu) || (cur_air > thr_air);

   // fan supervision
   logic [pchm_pkg::SPEED_W-1:0] speed_cpu_fan;
   logic [pchm_pkg::SPEED_W-1:0] speed_psu_fan;
   logic                         fail_cpu_fan;
   logic                         fail_psu_fan;

   pchm_fan_tach u_fan_cpu (
      .clk       (clk),
      .rst       (rst),
      .sec_tick  (sec_tick),
      .tach      (tach_cpu_fan),
      .min_speed (fan_min),
      .speed     (speed_cpu_fan),
      .fail      (fail_cpu_fan)
   );

   pchm_fan_tach u_fan_psu (
      .clk       (clk),
      .rst       (rst),
      .sec_tick  (sec_tick),
      .tach      (tach_psu_fan),
      .min_speed (fan_min),
      .speed     (speed_psu_fan),
      .fail      (fail_psu_fan)
   );

   wire any_fan_fail = fail_cpu_fan || fail_psu_fan;

   // supervisor countdown
   pchm_pkg::pchm_wd_state_e    wd_state;
   pchm_pkg::pchm_wd_state_e    next_wd_state;
   logic [pchm_pkg::TOUT_W-1:0] wd_count;
   logic [pchm_pkg::TOUT_W-1:0] next_wd_count;
   logic                        wd_expire;

   wire wd_reload = wr_retrig || wr_timeout;
   wire wd_load_value_sel = wr_timeout;

   always_comb begin
      next_wd_state = wd_state;
      next_wd_count = wd_count;
      wd_expire     = 1'b0;
      case (wd_state)
         pchm_pkg::PCHM_WD_IDLE: begin
            if (program_supervisor_en) begin
               next_wd_state = pchm_pkg::PCHM_WD_RUN;
               next_wd_count = supervisor_timeout_seconds;
            end
         end
         pchm_pkg::PCHM_WD_RUN: begin
            if (!program_supervisor_en) begin
               next_wd_state = pchm_pkg::PCHM_WD_IDLE;
            end else if (wd_reload) begin
               next_wd_count = wd_load_value_sel ? next_timeout : supervisor_timeout_seconds;
            end else if (sec_tick) begin
               next_wd_count = wd_count - 8'h01;
               if (wd_count == 8'h01) begin
                  next_wd_state = pchm_pkg::PCHM_WD_EXPIRED;
                  wd_expire     = 1'b1;
               end
            end
         end
         pchm_pkg::PCHM_WD_EXPIRED: begin
            if (!program_supervisor_en) begin
               next_wd_state = pchm_pkg::PCHM_WD_IDLE;
            end else if (wd_reload) begin
               next_wd_state = pchm_pkg::PCHM_WD_RUN;
               next_wd_count = wd_load_value_sel ? next_timeout : supervisor_timeout_seconds;
            end
         end
         default: begin
            next_wd_state = pchm_pkg::PCHM_WD_IDLE;
            next_wd_count = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wd_state <= pchm_pkg::PCHM_WD_IDLE;
         wd_count <= '0;
      end else begin
         wd_state <= next_wd_state;
         wd_count <= next_wd_count;
      end
   end

   // latched error flags; a new cause wins over an acknowledge
   logic err_temp;
   logic err_wd;
   logic err_fan;

   wire ack_temp = wr_error && wr_data[pchm_pkg::ERR_TEMP_BIT];
   wire ack_wd   = wr_error && wr_data[pchm_pkg::ERR_WD_BIT];
   wire ack_fan  = wr_error && wr_data[pchm_pkg::ERR_FAN_BIT];

   wire next_err_temp = any_over || (err_temp && !ack_temp);
   wire next_err_wd   = wd_expire || (err_wd && !ack_wd);
   wire next_err_fan  = any_fan_fail || (err_fan && !ack_fan);

   always_ff @(posedge clk) begin
      if (rst) begin
         err_temp <= 1'b0;
         err_wd   <= 1'b0;
         err_fan  <= 1'b0;
      end else begin
         err_temp <= next_err_temp;
         err_wd   <= next_err_wd;
         err_fan  <= next_err_fan;
      end
   end

   // interrupt status, clear and enable
   logic [pchm_pkg::EVT_W-1:0] irq_status;

   wire [pchm_pkg::EVT_W-1:0] evt_set = {any_fan_fail, wd_expire, any_over};
   wire [pchm_pkg::EVT_W-1:0] evt_clr = wr_irq_clr ? wr_data[pchm_pkg::EVT_W-1:0] : pchm_pkg::EVT_RST;
   wire [pchm_pkg::EVT_W-1:0] next_irq_status = evt_set | (irq_status & ~evt_clr);
   wire                       next_irq = |(next_irq_status & irq_enable);

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status <= pchm_pkg::EVT_RST;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq        <= next_irq;
      end
   end

   // fan override and system reset pulse
   logic [pchm_pkg::PULSE_W-1:0] reset_pulse_cnt;

   wire next_fan_full = any_over || err_temp;
   wire reset_start   = wd_expire && reset_react_en;
   wire reset_busy    = (reset_pulse_cnt != '0);

   always_ff @(posedge clk) begin
      if (rst) begin
         fan_full_speed  <= 1'b0;
         reset_pulse_cnt <= '0;
         system_reset    <= 1'b0;
      end else begin
         fan_full_speed <= next_fan_full;
         if (reset_start) begin
            reset_pulse_cnt <= pchm_pkg::PULSE_W'(pchm_pkg::RESET_PULSE_CYCLES);
         end else if (reset_busy) begin
            reset_pulse_cnt <= reset_pulse_cnt - 5'h01;
         end
         system_reset <= reset_start || (reset_pulse_cnt > 5'h01);
      end
   end

   // read path
   logic [pchm_pkg::DATA_W-1:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      case (addr)
         pchm_pkg::ADDR_CTRL:       rd_mux = {14'h0000, ctrl};
         pchm_pkg::ADDR_TIMEOUT:    rd_mux = {8'h00, supervisor_timeout_seconds};
         pchm_pkg::ADDR_WD_COUNT:   rd_mux = {8'h00, wd_count};
         pchm_pkg::ADDR_THR_CPU:    rd_mux = {8'h00, thr_cpu};
         pchm_pkg::ADDR_THR_PSU:    rd_mux = {8'h00, thr_psu};
         pchm_pkg::ADDR_THR_AIR:    rd_mux = {8'h00, thr_air};
         pchm_pkg::ADDR_TEMP_CPU:   rd_mux = {8'h00, cur_cpu};
         pchm_pkg::ADDR_TEMP_PSU:   rd_mux = {8'h00, cur_psu};
         pchm_pkg::ADDR_TEMP_AIR:   rd_mux = {8'h00, cur_air};
         pchm_pkg::ADDR_SPEED_CPU:  rd_mux = speed_cpu_fan;
         pchm_pkg::ADDR_SPEED_PSU:  rd_mux = speed_psu_fan;
         pchm_pkg::ADDR_ERROR:      rd_mux = {13'h0000, err_fan, err_wd, err_temp};
         pchm_pkg::ADDR_IRQ_STATUS: rd_mux = {13'h0000, irq_status};
         pchm_pkg::ADDR_IRQ_ENABLE: rd_mux = {13'h0000, irq_enable};
         pchm_pkg::ADDR_FAN_MIN:    rd_mux = fan_min;
         default:                   rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= rd_en ? rd_mux : '0;
      end
   end

endmodule : pchm_monitor

// ---- include/pchm_pkg.sv ----
package pchm_pkg;

   // bus and data widths
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 16;
   localparam int TEMP_W  = 8;
   localparam int SPEED_W = 16;
   localparam int TOUT_W  = 8;
   localparam int TICK_W  = 24;
   localparam int PULSE_W = 5;

   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_CTRL       = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_TIMEOUT    = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_RETRIGGER  = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_WD_COUNT   = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_THR_CPU    = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_THR_PSU    = 8'h05;
   localparam logic [ADDR_W-1:0] ADDR_THR_AIR    = 8'h06;
   localparam logic [ADDR_W-1:0] ADDR_TEMP_CPU   = 8'h07;
   localparam logic [ADDR_W-1:0] ADDR_TEMP_PSU   = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_TEMP_AIR   = 8'h09;
   localparam logic [ADDR_W-1:0] ADDR_SPEED_CPU  = 8'h0A;
   localparam logic [ADDR_W-1:0] ADDR_SPEED_PSU  = 8'h0B;
   localparam logic [ADDR_W-1:0] ADDR_ERROR      = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h0D;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR  = 8'h0E;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h0F;
   localparam logic [ADDR_W-1:0] ADDR_FAN_MIN    = 8'h10;

   // field positions
   localparam int CTRL_WD_EN_BIT  = 0;
   localparam int CTRL_RST_EN_BIT = 1;
   localparam int ERR_TEMP_BIT    = 0;
   localparam int ERR_WD_BIT      = 1;
   localparam int ERR_FAN_BIT     = 2;
   localparam int EVT_W           = 3;

   // threshold and timeout limits, degrees celsius and seconds
   localparam logic [TEMP_W-1:0] THR_PSU_MIN = 8'h28;
   localparam logic [TEMP_W-1:0] THR_PSU_MAX = 8'h50;
   localparam logic [TEMP_W-1:0] THR_AIR_MIN = 8'h19;
   localparam logic [TEMP_W-1:0] THR_AIR_MAX = 8'h41;
   localparam logic [TOUT_W-1:0] TOUT_MIN    = 8'h03;
   localparam logic [TOUT_W-1:0] TOUT_MAX    = 8'hFF;

   // values after reset
   localparam logic [1:0]         CTRL_RST     = 2'h0;
   localparam logic [TOUT_W-1:0]  TOUT_RST     = 8'h3C;
   localparam logic [TEMP_W-1:0]  THR_CPU_RST  = 8'h5A;
   localparam logic [TEMP_W-1:0]  THR_PSU_RST  = 8'h50;
   localparam logic [TEMP_W-1:0]  THR_AIR_RST  = 8'h41;
   localparam logic [SPEED_W-1:0] FAN_MIN_RST  = 16'h0010;
   localparam logic [EVT_W-1:0]   EVT_RST      = 3'h0;

   // timebase
   localparam int CLK_PERIOD_NS      = 100;
   localparam int SECOND_NS          = 1000000000;
   localparam int SEC_CYCLES         = SECOND_NS / CLK_PERIOD_NS;
   localparam int RESET_PULSE_CYCLES = 16;

   typedef enum logic [1:0] {
      PCHM_WD_IDLE    = 2'h0,
      PCHM_WD_RUN     = 2'h1,
      PCHM_WD_EXPIRED = 2'h3
   } pchm_wd_state_e;

endpackage : pchm_pkg

// ---- verif/pchm_monitor_chk.sv ----
`timescale 1ns/1ps
module pchm_monitor_chk #(
   parameter int TICKS_PER_SEC = 8
) (
   input wire logic                        clk,
   input wire logic                        rst,
   input wire logic [pchm_pkg::ADDR_W-1:0] addr,
   input wire logic [pchm_pkg::DATA_W-1:0] wr_data,
   input wire logic                        wr_en,
   input wire logic                        rd_en,
   input wire logic [pchm_pkg::DATA_W-1:0] rd_data,
   input wire logic [pchm_pkg::TEMP_W-1:0] temp_psu,
   input wire logic [pchm_pkg::TEMP_W-1:0] temp_air,
   input wire logic                        fan_full_speed,
   input wire logic                        system_reset,
   input wire logic                        irq
);
   logic [1:0]  ctrl_sh;
   logic [2:0]  en_sh;
   int unsigned since_kick;
   wire         ctrl_wr = wr_en && (addr == pchm_pkg::ADDR_CTRL);
   wire         kick    = (ctrl_wr && wr_data[0] && !ctrl_sh[0]) ||
                          (wr_en && (addr == pchm_pkg::ADDR_RETRIGGER || addr == pchm_pkg::ADDR_TIMEOUT));
   // shadow of control and mask writes, cycles since the last countdown load
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_sh <= '0;
         en_sh <= '0;
         since_kick <= 0;
      end else begin
         if (ctrl_wr) ctrl_sh <= wr_data[1:0];
         if (wr_en && addr == pchm_pkg::ADDR_IRQ_ENABLE) en_sh <= wr_data[2:0];
         since_kick <= kick ? 0 : since_kick + 1;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   hot_psu_fan_a: assert property ((temp_psu > pchm_pkg::THR_PSU_MAX) [*3] |-> fan_full_speed)
      else $error("fans not forced on hot supply area");
   hot_air_fan_a: assert property ((temp_air > pchm_pkg::THR_AIR_MAX) [*3] |-> fan_full_speed)
      else $error("fans not forced on hot intake air");
   fan_hold_a: assert property ($fell(fan_full_speed) |-> $past(wr_en) || $past(wr_en, 2))
      else $error("fan force dropped without acknowledge");
   wd_idle_a: assert property ($rose(system_reset) |-> ctrl_sh == 2'h3)
      else $error("system reset without enable");
   rst_hold_a: assert property ($rose(system_reset) |-> system_reset [*8])
      else $error("system reset pulse too short");
   rst_end_a: assert property ($rose(system_reset) |-> ##16 !system_reset)
      else $error("system reset pulse too long");
   kick_gap_a: assert property ($rose(system_reset) |-> since_kick >= 2 * TICKS_PER_SEC)
      else $error("expiry earlier than minimum timeout");
   irq_rise_a: assert property ($rose(irq) |-> $past(en_sh) != 3'h0)
      else $error("interrupt while masked");
   rd_idle_a: assert property (!$past(rd_en) |-> rd_data == '0)
      else $error("read data outside read cycle");
   fan_c: cover property ($rose(fan_full_speed));
   reset_c: cover property ($rose(system_reset));
   irq_c: cover property ($rose(irq));
endmodule : pchm_monitor_chk
bind pchm_monitor pchm_monitor_chk #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_pchm_monitor_chk (
   .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .temp_psu(temp_psu), .temp_air(temp_air), .fan_full_speed(fan_full_speed), .system_reset(system_reset),
   .irq(irq));

// ---- verif/pchm_monitor_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module pchm_monitor_test;
   localparam int T = 8;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wr_data = 16'h0000;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [15:0] rd_data;
   logic [7:0]  temp_cpu = 8'h20;
   logic [7:0]  temp_psu = 8'h21;
   logic [7:0]  temp_air = 8'h22;
   logic        tach_cpu_fan = 1'b0;
   logic        tach_psu_fan = 1'b0;
   logic        fan_full_speed, system_reset, irq;
   logic        run_cpu = 1'b0;
   logic        run_psu = 1'b0;
   logic [15:0] d;
   int          n_errors = 0;
   int          n_checks = 0;
   int          i, k;
   logic [7:0]  ca [10] = '{8'h04, 8'h05, 8'h05, 8'h05, 8'h06, 8'h06, 8'h01, 8'h01, 8'h01, 8'h01};
   logic [7:0]  cw [10] = '{8'h60, 8'h10, 8'h90, 8'h3C, 8'h05, 8'hFF, 8'h01, 8'h02, 8'hFF, 8'h03};
   logic [7:0]  ce [10] = '{8'h60, 8'h28, 8'h50, 8'h3C, 8'h19, 8'h41, 8'h03, 8'h03, 8'hFF, 8'h03};

   pchm_monitor #(.TICKS_PER_SEC(T)) u_pchm_monitor (
      .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .temp_cpu(temp_cpu), .temp_psu(temp_psu), .temp_air(temp_air), .tach_cpu_fan(tach_cpu_fan),
      .tach_psu_fan(tach_psu_fan), .fan_full_speed(fan_full_speed), .system_reset(system_reset), .irq(irq));

   initial begin
      forever #50 clk = ~clk;
   end
   // tach pulses: one rising edge every two cycles while running
   always @(posedge clk) begin
      if (run_cpu) tach_cpu_fan <= ~tach_cpu_fan;
      if (run_psu) tach_psu_fan <= ~tach_psu_fan;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask : rd
   task automatic cr(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
      rd(a);
      `CHK($sformatf("reg %h", a), e, d & m)
   endtask : cr
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #(100000 * 100);
      n_errors++;
      wrap_up();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      cr(pchm_pkg::ADDR_CTRL, 16'hFFFF, 16'h0000);
      cr(pchm_pkg::ADDR_TIMEOUT, 16'hFFFF, 16'h003C);
      cr(pchm_pkg::ADDR_THR_CPU, 16'hFFFF, 16'h005A);
      cr(pchm_pkg::ADDR_THR_PSU, 16'hFFFF, 16'h0050);
      cr(pchm_pkg::ADDR_THR_AIR, 16'hFFFF, 16'h0041);
      cr(8'h20, 16'hFFFF, 16'h0000);
      for (i = 0; i < 10; i++) begin
         wr(ca[i], {8'hA5, cw[i]});
         cr(ca[i], 16'hFFFF, {8'h00, ce[i]});
      end
      cr(pchm_pkg::ADDR_TEMP_CPU, 16'hFFFF, 16'h0020);
      cr(pchm_pkg::ADDR_TEMP_PSU, 16'hFFFF, 16'h0021);
      cr(pchm_pkg::ADDR_TEMP_AIR, 16'hFFFF, 16'h0022);
      // over-temperature and its acknowledge
      wr(pchm_pkg::ADDR_IRQ_ENABLE, 16'h0001);
      @(posedge clk);
      temp_air <= 8'h50;
      cyc(3);
      `CHK("fan_full_speed", 1'b1, fan_full_speed)
      cr(pchm_pkg::ADDR_IRQ_STATUS, 16'h0001, 16'h0001);
      `CHK("irq", 1'b1, irq)
      wr(pchm_pkg::ADDR_ERROR, 16'h0001);
      cr(pchm_pkg::ADDR_ERROR, 16'h0001, 16'h0001);
      @(posedge clk);
      temp_air <= 8'h22;
      cyc(3);
      `CHK("fan_full_speed", 1'b1, fan_full_speed)
      wr(pchm_pkg::ADDR_ERROR, 16'h0001);
      cyc(2);
      cr(pchm_pkg::ADDR_ERROR, 16'h0001, 16'h0000);
      `CHK("fan_full_speed", 1'b0, fan_full_speed)
      wr(pchm_pkg::ADDR_IRQ_ENABLE, 16'h0000);
      cyc(2);
      `CHK("irq", 1'b0, irq)
      wr(pchm_pkg::ADDR_IRQ_CLEAR, 16'h0007);
      // fan supervision
      wr(pchm_pkg::ADDR_FAN_MIN, 16'h0002);
      run_cpu <= 1'b1;
      run_psu <= 1'b1;
      cyc(2 * T + 4);
      cr(pchm_pkg::ADDR_SPEED_CPU, 16'hFFFF, 16'h0004);
      cr(pchm_pkg::ADDR_SPEED_PSU, 16'hFFFF, 16'h0004);
      wr(pchm_pkg::ADDR_ERROR, 16'h0004);
      cr(pchm_pkg::ADDR_ERROR, 16'h0004, 16'h0000);
      run_psu <= 1'b0;
      cyc(2 * T + 4);
      cr(pchm_pkg::ADDR_SPEED_PSU, 16'hFFFF, 16'h0000);
      cr(pchm_pkg::ADDR_ERROR, 16'h0004, 16'h0004);
      wr(pchm_pkg::ADDR_ERROR, 16'h0004);
      cr(pchm_pkg::ADDR_ERROR, 16'h0004, 16'h0004);
      run_psu <= 1'b1;
      cyc(2 * T + 4);
      wr(pchm_pkg::ADDR_ERROR, 16'h0004);
      cr(pchm_pkg::ADDR_ERROR, 16'h0004, 16'h0000);
      // supervisor: load, retrigger, reload by timeout write, expiry
      wr(pchm_pkg::ADDR_IRQ_ENABLE, 16'h0002);
      wr(pchm_pkg::ADDR_CTRL, 16'h0001);
      rd(pchm_pkg::ADDR_WD_COUNT);
      `CHK("wd_count loaded", 1'b1, d >= 16'h0002 && d <= 16'h0003)
      repeat (6) begin
         cyc(T);
         wr(pchm_pkg::ADDR_RETRIGGER, 16'h0000);
      end
      cr(pchm_pkg::ADDR_ERROR, 16'h0002, 16'h0000);
      cyc(T + T / 2);
      wr(pchm_pkg::ADDR_TIMEOUT, 16'h0004);
      rd(pchm_pkg::ADDR_WD_COUNT);
      `CHK("wd_count reload", 1'b1, d >= 16'h0003 && d <= 16'h0004)
      cyc(6 * T);
      cr(pchm_pkg::ADDR_ERROR, 16'h0002, 16'h0002);
      `CHK("irq", 1'b1, irq)
      cr(pchm_pkg::ADDR_WD_COUNT, 16'hFFFF, 16'h0000);
      `CHK("system_reset", 1'b0, system_reset)
      // expiry with system reset reaction
      wr(pchm_pkg::ADDR_CTRL, 16'h0000);
      wr(pchm_pkg::ADDR_ERROR, 16'h0002);
      wr(pchm_pkg::ADDR_TIMEOUT, 16'h0003);
      wr(pchm_pkg::ADDR_CTRL, 16'h0003);
      k = 0;
      while (system_reset !== 1'b1 && k < 5 * T) begin
         cyc(1);
         k++;
      end
      `CHK("system_reset", 1'b1, system_reset)
      if (system_reset !== 1'b1) wrap_up();
      k = 0;
      while (system_reset === 1'b1 && k < 40) begin
         cyc(1);
         k++;
      end
      `CHK("reset width", pchm_pkg::RESET_PULSE_CYCLES, k)
      wr(pchm_pkg::ADDR_CTRL, 16'h0000);
      wr(pchm_pkg::ADDR_ERROR, 16'h0002);
      wr(pchm_pkg::ADDR_IRQ_CLEAR, 16'h0007);
      cyc(2);
      `CHK("irq", 1'b0, irq)
      // second restart in mid-run, supervisor armed, leaves it idle
      wr(pchm_pkg::ADDR_CTRL, 16'h0003);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cr(pchm_pkg::ADDR_CTRL, 16'hFFFF, 16'h0000);
      wr(pchm_pkg::ADDR_TIMEOUT, 16'h0003);
      cyc(6 * T);
      cr(pchm_pkg::ADDR_ERROR, 16'h0002, 16'h0000);
      `CHK("system_reset", 1'b0, system_reset)
      // supply area over its restored threshold forces the fans
      @(posedge clk);
      temp_psu <= 8'h51;
      cyc(3);
      `CHK("fan_full_speed", 1'b1, fan_full_speed)
      wrap_up();
   end
endmodule : pchm_monitor_test
